// ==== verification/tpio_asserts.sv ====
module tpio_asserts (
  input wire clk,
  input wire rst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [7:0] first_port_lines_in,
  input wire [7:0] first_port_lines_oe,
  input wire [7:0] first_port_lines_out,
  input wire [7:0] second_port_lines_in,
  input wire [7:0] second_port_lines_oe,
  input wire [7:0] second_port_lines_out,
  input wire [7:0] third_port_lines_in,
  input wire [7:0] third_port_lines_oe,
  input wire [7:0] third_port_lines_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire ok = ~avs_waitrequest & (avs_address[1:0] == 2'h0);
  wire wok = ok & avs_write & avs_byteenable[0];
  wire rok = ok & avs_read;
  wire [1:0] ix = avs_address[3:2];
  property p_idle;
    $rose(rst_n) |-> {first_port_lines_oe, second_port_lines_oe,
      third_port_lines_oe} == 24'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("lines driven after reset");
  property p_answer;
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_a_wr;
    wok && ix == 2'h0 && first_port_lines_oe == 8'hff |->
      ##2 first_port_lines_out == $past(avs_writedata[7:0], 2);
  endproperty
  a_a_wr: assert property (p_a_wr) else $error("port a not driven");
  property p_b_wr;
    wok && ix == 2'h1 && second_port_lines_oe == 8'hff |->
      ##2 second_port_lines_out == $past(avs_writedata[7:0], 2);
  endproperty
  a_b_wr: assert property (p_b_wr) else $error("port b not driven");
  property p_c_wr;
    wok && ix == 2'h2 && third_port_lines_oe == 8'hff |->
      ##2 third_port_lines_out == $past(avs_writedata[7:0], 2);
  endproperty
  a_c_wr: assert property (p_c_wr) else $error("port c not driven");
  property p_dir;
    wok && ix == 2'h3 && avs_writedata[7] |-> ##2
      first_port_lines_oe == {8{~$past(avs_writedata[4], 2)}} &&
      second_port_lines_oe == {8{~$past(avs_writedata[1], 2)}};
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_rd_a;
    rok && ix == 2'h0 && $stable(first_port_lines_in) &&
      $past(first_port_lines_in, 3) == first_port_lines_in &&
      third_port_lines_oe[7:4] inside {4'h0, 4'hf}
      |-> avs_readdata == {24'h0, first_port_lines_in};
  endproperty
  a_rd_a: assert property (p_rd_a) else $error("port a read wrong");
  property p_rd_b;
    rok && ix == 2'h1 && $stable(second_port_lines_in) &&
      $past(second_port_lines_in, 3) == second_port_lines_in &&
      third_port_lines_oe[2:0] inside {3'h0, 3'h7}
      |-> avs_readdata == {24'h0, second_port_lines_in};
  endproperty
  a_rd_b: assert property (p_rd_b) else $error("port b read wrong");
  property p_ibf;
    $fell(third_port_lines_in[2]) && third_port_lines_oe[2:0] == 3'h3
      |-> ##[1:3] third_port_lines_out[1];
  endproperty
  a_ibf: assert property (p_ibf) else $error("full flag not set");
endmodule

bind tpio_top tpio_asserts u_chk (.clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .first_port_lines_in, .first_port_lines_oe,
  .first_port_lines_out, .second_port_lines_in, .second_port_lines_oe,
  .second_port_lines_out, .third_port_lines_in, .third_port_lines_oe,
  .third_port_lines_out);

// ==== verification/tpio_far_end.sv ====
module tpio_far_end (
  input wire [23:0] out,
  input wire [23:0] oe,
  input wire [23:0] ext,
  output wire [23:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven lines show whatever the equipment puts on them.
  assign lines = (out & oe) | (ext & ~oe);
endmodule

// ==== verification/tpio_tb_top.sv ====
module tpio_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdat, got;
  logic wreq;
  logic [23:0] out, oe, lines;
  logic [23:0] ext = 24'hffffff;
  logic [39:0] r;
  int num_errors = 0;
  int n_compared = 0;
  int i;
  // Row: setup word, port, data written, far-end level, expected enables.
  logic [39:0] rows [8] = '{
    {8'h80, 8'h0, 8'h5a, 8'h00, 8'hff}, {8'h80, 8'h1, 8'ha5, 8'h00, 8'hff},
    {8'h80, 8'h2, 8'h3c, 8'h00, 8'hff}, {8'h9b, 8'h0, 8'h77, 8'hc3, 8'h00},
    {8'h9b, 8'h1, 8'h77, 8'h96, 8'h00}, {8'h9b, 8'h2, 8'h77, 8'h69, 8'h00},
    {8'h88, 8'h2, 8'hff, 8'h50, 8'h0f}, {8'h81, 8'h2, 8'h0f, 8'ha0, 8'hf0}};

  always #20 clk = ~clk;

  tpio_top DUT (.clk, .rst_n, .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq),
    .first_port_lines_in(lines[7:0]), .first_port_lines_out(out[7:0]),
    .first_port_lines_oe(oe[7:0]), .second_port_lines_in(lines[15:8]),
    .second_port_lines_out(out[15:8]), .second_port_lines_oe(oe[15:8]),
    .third_port_lines_in(lines[23:16]), .third_port_lines_out(out[23:16]),
    .third_port_lines_oe(oe[23:16]));

  tpio_far_end u_far (.out, .oe, .ext, .lines);

  task chk(input [31:0] g, input [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wrap_up;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The request stands until waitrequest is seen low at a rising edge;
  // read data is taken at that same edge and only then is it released.
  task xfer(input is_rd, input [3:0] a, input [7:0] d, input [3:0] b);
    int n;
    @(posedge clk);
    rd <= is_rd;
    wr <= ~is_rd;
    adr <= a;
    wdat <= {24'h0, d};
    be <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        num_errors++;
        wrap_up();
      end
    end while (wreq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task wr8(input [1:0] x, input [7:0] d);
    xfer(1'b0, {x, 2'h0}, d, 4'h1);
  endtask

  task rd8(input [1:0] x);
    xfer(1'b1, {x, 2'h0}, 8'h0, 4'h1);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(oe, 24'h0);
    rd8(2'h3);
    chk(got, 32'h0);
    foreach (rows[k]) begin
      r = rows[k];
      i = r[25:24];
      ext <= {3{r[15:8]}};
      wr8(2'h3, r[39:32]);
      wr8(r[25:24], r[23:16]);
      repeat (3) @(posedge clk);
      rd8(r[25:24]);
      chk(got, (r[23:16] & r[7:0]) | (r[15:8] & ~r[7:0]));
      chk(oe[8*i +: 8], r[7:0]);
      chk(out[8*i +: 8] & r[7:0], r[23:16] & r[7:0]);
    end
    wr8(2'h3, 8'h80);
    wr8(2'h0, 8'h11);
    xfer(1'b0, 4'h0, 8'hee, 4'h0);
    xfer(1'b0, 4'h1, 8'hdd, 4'h1);
    repeat (3) @(posedge clk);
    chk(out[7:0], 8'h11);
    ext <= 24'hffe1ff;
    wr8(2'h3, 8'h86);
    // Let the new enables settle so the byte is caught from the far end.
    repeat (2) @(posedge clk);
    ext[18] <= 1'b0;
    repeat (2) @(posedge clk);
    ext[18] <= 1'b1;
    repeat (4) @(posedge clk);
    chk(out[17], 1'b1);
    chk(oe[18:16], 3'h3);
    ext[15:8] <= 8'h00;
    rd8(2'h1);
    chk(got, 32'he1);
    repeat (3) @(posedge clk);
    chk(out[17], 1'b0);
    ext <= 24'hffffff;
    wr8(2'h3, 8'h84);
    wr8(2'h1, 8'h3c);
    repeat (3) @(posedge clk);
    chk(out[15:8], 8'h3c);
    chk(out[17], 1'b0);
    ext[18] <= 1'b0;
    repeat (3) @(posedge clk);
    chk(out[17], 1'b1);
    wr8(2'h3, 8'h80);
    rst_n <= 1'b0;
    @(posedge clk);
    chk(oe, 24'h0);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wr8(2'h0, 8'h42);
    repeat (3) @(posedge clk);
    chk(oe, 24'h0);
    wrap_up();
  end
endmodule

// ==== verilog/tpio_port_slice.v ====
`include "tpio_regs.vh"

// One 8-line port: output latch, strobed input latch and line drive.
module tpio_port_slice #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire wr_stb,
  input wire [WIDTH-1:0] wr_data,
  input wire strobe_latch,
  input wire drive_en,
  input wire [WIDTH-1:0] lines_in,
  output reg [WIDTH-1:0] lines_out,
  output reg [WIDTH-1:0] lines_oe,
  output reg [WIDTH-1:0] latched_in
);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lines_out <= {WIDTH{1'b0}};
      lines_oe <= {WIDTH{1'b0}};
      latched_in <= {WIDTH{1'b0}};
    end else begin
      // A new setup word drops whatever was latched before.
      if (clear) begin
        lines_out <= {WIDTH{1'b0}};
      end else if (wr_stb) begin
        lines_out <= wr_data;
      end
      lines_oe <= {WIDTH{drive_en}};
      if (clear) begin
        latched_in <= {WIDTH{1'b0}};
      end else if (strobe_latch) begin
        latched_in <= lines_in;
      end
    end
  end

endmodule

// ==== verilog/tpio_regs.vh ====
`ifndef TPIO_REGS_VH
`define TPIO_REGS_VH

// ---------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ---------------------------------------------------------------------
`define TPIO_IDX_PORT_A 2'h0
`define TPIO_IDX_PORT_B 2'h1
`define TPIO_IDX_PORT_C 2'h2
`define TPIO_IDX_SETUP 2'h3

// ---------------------------------------------------------------------
// Setup word fields.
// ---------------------------------------------------------------------
`define TPIO_SETUP_MODE_SET 7
`define TPIO_SETUP_A_MODE_HI 6
`define TPIO_SETUP_A_MODE_LO 5
`define TPIO_SETUP_A_IN 4
`define TPIO_SETUP_CU_IN 3
`define TPIO_SETUP_B_MODE 2
`define TPIO_SETUP_B_IN 1
`define TPIO_SETUP_CL_IN 0
`define TPIO_SETUP_RESET 8'h9b

// ---------------------------------------------------------------------
// Third port bits taken over by the strobed modes.
// ---------------------------------------------------------------------
`define TPIO_PC_INTR_B 0
`define TPIO_PC_FLAG_B 1
`define TPIO_PC_HS_B 2
`define TPIO_PC_INTR_A 3
`define TPIO_PC_STB_A 4
`define TPIO_PC_IBF_A 5
`define TPIO_PC_ACK_A 6
`define TPIO_PC_OBF_A 7

`endif

// ==== verilog/tpio_top.v ====
`include "tpio_regs.vh"

// Overview of operation
// - Three 8-bit ports, 24 lines total.
// - Two 12-line groups or three 8-bit ports.
// - First port read returns its line levels, or its strobed byte in strobed input mode.
// - Output first port drives the written byte.
// - Second port read returns its line levels, or its strobed byte in strobed input mode.
// - Output second port drives the written byte.
// - Third port is plain without strobed modes.
// - Strobed modes borrow third port bits.
// - Setup word sets directions and transfer modes.
module tpio_top (
  input wire clk,
  input wire rst_n,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [7:0] first_port_lines_in,
  output wire [7:0] first_port_lines_out,
  output wire [7:0] first_port_lines_oe,
  input wire [7:0] second_port_lines_in,
  output wire [7:0] second_port_lines_out,
  output wire [7:0] second_port_lines_oe,
  input wire [7:0] third_port_lines_in,
  output reg [7:0] third_port_lines_out,
  output reg [7:0] third_port_lines_oe
);

  // -------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------
  // Handshake request level for a strobed port. An input port asks for
  // service once a byte is held and the strobe has gone back high; an
  // output port asks once the far side has taken the byte.
  function intr_level;
    input is_in;
    input in_full;
    input out_full;
    input enable;
    input hs_pin;
    begin
      if (is_in) begin
        intr_level = in_full & enable & hs_pin;
      end else begin
        intr_level = ~out_full & enable & hs_pin;
      end
    end
  endfunction

  // Mux of handshake status over plain line levels.
  function [7:0] merge_bits;
    input [7:0] sel;
    input [7:0] taken;
    input [7:0] plain;
    begin
      merge_bits = (sel & taken) | (~sel & plain);
    end
  endfunction

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  reg [7:0] setup_q;
  reg [7:0] pc_q;
  reg ack_q;
  // Input-full and output-full flags of the two strobed ports.
  reg ibf_a_q;
  reg ibf_b_q;
  reg obf_a_q;
  reg obf_b_q;
  reg stb_a_prev_q;
  reg stb_b_prev_q;

  wire [7:0] latch_a;
  wire [7:0] latch_b;

  // -------------------------------------------------------------------
  // Setup word decode
  // -------------------------------------------------------------------
  // All three two-bit mode codes above zero give the strobed one-way mode;
  // the bidirectional bus mode is not offered by this block.
  wire a_strobed = setup_q[`TPIO_SETUP_A_MODE_HI] |
                   setup_q[`TPIO_SETUP_A_MODE_LO];
  wire a_in = setup_q[`TPIO_SETUP_A_IN];
  wire cu_in = setup_q[`TPIO_SETUP_CU_IN];
  wire b_strobed = setup_q[`TPIO_SETUP_B_MODE];
  wire b_in = setup_q[`TPIO_SETUP_B_IN];
  wire cl_in = setup_q[`TPIO_SETUP_CL_IN];

  // -------------------------------------------------------------------
  // Avalon-MM slave
  // -------------------------------------------------------------------
  // One wait state: read data is registered in the first cycle and the
  // access takes effect at the edge where waitrequest is seen low.
  wire req = avs_read | avs_write;
  wire mapped = (avs_address[1:0] == 2'h0);
  wire [1:0] idx = avs_address[3:2];
  wire wr_fire = avs_write & ack_q & mapped & avs_byteenable[0];
  wire rd_fire = avs_read & ack_q & mapped;
  wire [7:0] wd = avs_writedata[7:0];

  assign avs_waitrequest = req & ~ack_q;

  // A misaligned address is still answered; its write is dropped and
  // its read returns zero, so a stray access can never hang the bus.

  wire wr_a = wr_fire & (idx == `TPIO_IDX_PORT_A);
  wire wr_b = wr_fire & (idx == `TPIO_IDX_PORT_B);
  wire wr_c = wr_fire & (idx == `TPIO_IDX_PORT_C);
  wire wr_setup = wr_fire & (idx == `TPIO_IDX_SETUP);
  wire mode_set = wr_setup & wd[`TPIO_SETUP_MODE_SET];
  wire bit_op = wr_setup & ~wd[`TPIO_SETUP_MODE_SET];
  wire rd_a = rd_fire & (idx == `TPIO_IDX_PORT_A);
  wire rd_b = rd_fire & (idx == `TPIO_IDX_PORT_B);

  // -------------------------------------------------------------------
  // Handshake pins and flags
  // -------------------------------------------------------------------
  // Strobe and acknowledge inputs are active low and idle high, so the
  // edge detectors reset to one and see no false edge after reset.
  wire stb_a_n = third_port_lines_in[`TPIO_PC_STB_A];
  wire ack_a_n = third_port_lines_in[`TPIO_PC_ACK_A];
  wire hs_b_n = third_port_lines_in[`TPIO_PC_HS_B];

  wire a_in_hs = a_strobed & a_in;
  wire a_out_hs = a_strobed & ~a_in;
  wire b_in_hs = b_strobed & b_in;
  wire b_out_hs = b_strobed & ~b_in;

  // The enable bits live in the third port latch, set by bit operations.
  wire inte_a = a_in ? pc_q[`TPIO_PC_STB_A] : pc_q[`TPIO_PC_ACK_A];
  wire inte_b = pc_q[`TPIO_PC_HS_B];

  // A strobe is a falling edge on the pin while the port is a strobed
  // input; the byte on the lines is caught at that same edge.
  wire strobe_a = a_in_hs & stb_a_prev_q & ~stb_a_n;
  wire strobe_b = b_in_hs & stb_b_prev_q & ~hs_b_n;

  wire intr_a = a_strobed &
                intr_level(a_in, ibf_a_q, obf_a_q, inte_a,
                           a_in ? stb_a_n : ack_a_n);
  wire intr_b = b_strobed &
                intr_level(b_in, ibf_b_q, obf_b_q, inte_b, hs_b_n);

  // -------------------------------------------------------------------
  // Setup word, third port latch and handshake flags
  // -------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= `TPIO_SETUP_RESET;
      pc_q <= 8'h00;
      ack_q <= 1'b0;
      ibf_a_q <= 1'b0;
      ibf_b_q <= 1'b0;
      obf_a_q <= 1'b0;
      obf_b_q <= 1'b0;
      stb_a_prev_q <= 1'b1;
      stb_b_prev_q <= 1'b1;
    end else begin
      ack_q <= req & ~ack_q;
      stb_a_prev_q <= stb_a_n;
      stb_b_prev_q <= hs_b_n;
      // A setup byte with its top bit clear is a single-bit operation
      // on the third port latch and leaves the modes alone.
      if (mode_set) begin
        setup_q <= wd;
        pc_q <= 8'h00;
      end else if (bit_op) begin
        pc_q[wd[3:1]] <= wd[0];
      end else if (wr_c) begin
        pc_q <= wd;
      end
      // Flags: a mode set clears all; else a fresh event wins over a clear in the same cycle.
      if (mode_set) begin
        ibf_a_q <= 1'b0;
        ibf_b_q <= 1'b0;
        obf_a_q <= 1'b0;
        obf_b_q <= 1'b0;
      end else begin
        if (strobe_a) begin
          ibf_a_q <= 1'b1;
        end else if (rd_a) begin
          ibf_a_q <= 1'b0;
        end
        if (strobe_b) begin
          ibf_b_q <= 1'b1;
        end else if (rd_b) begin
          ibf_b_q <= 1'b0;
        end
        if (wr_a & a_out_hs) begin
          obf_a_q <= 1'b1;
        end else if (~ack_a_n) begin
          obf_a_q <= 1'b0;
        end
        if (wr_b & b_out_hs) begin
          obf_b_q <= 1'b1;
        end else if (~hs_b_n) begin
          obf_b_q <= 1'b0;
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // First and second ports
  // -------------------------------------------------------------------
  tpio_port_slice #(
    .WIDTH(8)
  ) u_first_port (
    .clk(clk),
    .rst_n(rst_n),
    .clear(mode_set),
    .wr_stb(wr_a),
    .wr_data(wd),
    .strobe_latch(strobe_a),
    .drive_en(~a_in),
    .lines_in(first_port_lines_in),
    .lines_out(first_port_lines_out),
    .lines_oe(first_port_lines_oe),
    .latched_in(latch_a)
  );

  tpio_port_slice #(
    .WIDTH(8)
  ) u_second_port (
    .clk(clk),
    .rst_n(rst_n),
    .clear(mode_set),
    .wr_stb(wr_b),
    .wr_data(wd),
    .strobe_latch(strobe_b),
    .drive_en(~b_in),
    .lines_in(second_port_lines_in),
    .lines_out(second_port_lines_out),
    .lines_oe(second_port_lines_oe),
    .latched_in(latch_b)
  );

  // -------------------------------------------------------------------
  // Third port: plain bits and borrowed handshake bits
  // -------------------------------------------------------------------
  // Borrowed bits: the lower three serve the second port and the upper
  // five the first. Status bits are what a read of the third port
  // returns in place of the line levels.
  reg [7:0] hs_used;
  reg [7:0] hs_drive;
  reg [7:0] hs_val;
  reg [7:0] hs_stat;
  reg [7:0] plain_oe;

  always @* begin
    hs_used = 8'h00;
    hs_drive = 8'h00;
    hs_val = 8'h00;
    hs_stat = 8'h00;
    plain_oe = {{4{~cu_in}}, {4{~cl_in}}};
    if (a_strobed) begin
      hs_used[`TPIO_PC_INTR_A] = 1'b1;
      hs_drive[`TPIO_PC_INTR_A] = 1'b1;
      hs_val[`TPIO_PC_INTR_A] = intr_a;
      hs_stat[`TPIO_PC_INTR_A] = intr_a;
    end
    if (a_in_hs) begin
      hs_used[`TPIO_PC_STB_A] = 1'b1;
      hs_used[`TPIO_PC_IBF_A] = 1'b1;
      hs_drive[`TPIO_PC_IBF_A] = 1'b1;
      hs_val[`TPIO_PC_IBF_A] = ibf_a_q;
      hs_stat[`TPIO_PC_IBF_A] = ibf_a_q;
      hs_stat[`TPIO_PC_STB_A] = inte_a;
    end
    if (a_out_hs) begin
      hs_used[`TPIO_PC_ACK_A] = 1'b1;
      hs_used[`TPIO_PC_OBF_A] = 1'b1;
      hs_drive[`TPIO_PC_OBF_A] = 1'b1;
      hs_val[`TPIO_PC_OBF_A] = ~obf_a_q;
      hs_stat[`TPIO_PC_OBF_A] = ~obf_a_q;
      hs_stat[`TPIO_PC_ACK_A] = inte_a;
    end
    if (b_strobed) begin
      hs_used[`TPIO_PC_INTR_B] = 1'b1;
      hs_used[`TPIO_PC_FLAG_B] = 1'b1;
      hs_used[`TPIO_PC_HS_B] = 1'b1;
      hs_drive[`TPIO_PC_INTR_B] = 1'b1;
      hs_drive[`TPIO_PC_FLAG_B] = 1'b1;
      hs_val[`TPIO_PC_INTR_B] = intr_b;
      hs_val[`TPIO_PC_FLAG_B] = b_in_hs ? ibf_b_q : ~obf_b_q;
      hs_stat[`TPIO_PC_INTR_B] = intr_b;
      hs_stat[`TPIO_PC_FLAG_B] = hs_val[`TPIO_PC_FLAG_B];
      hs_stat[`TPIO_PC_HS_B] = inte_b;
    end
  end

  // Registered so that the lines never glitch while flags settle.
  // A mode change therefore reaches these pins one cycle after the write.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      third_port_lines_out <= 8'h00;
      third_port_lines_oe <= 8'h00;
    end else begin
      third_port_lines_out <= merge_bits(hs_drive, hs_val, pc_q);
      third_port_lines_oe <= merge_bits(hs_used, hs_drive, plain_oe);
    end
  end

  // -------------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------------
  // Read data is loaded in the waiting cycle, so it already stands when
  // the master sees waitrequest low and takes it.
  reg [7:0] rd_byte;

  always @* begin
    case (idx)
      `TPIO_IDX_PORT_A: begin
        rd_byte = a_in_hs ? latch_a : first_port_lines_in;
      end
      `TPIO_IDX_PORT_B: begin
        rd_byte = b_in_hs ? latch_b : second_port_lines_in;
      end
      `TPIO_IDX_PORT_C: begin
        rd_byte = merge_bits(hs_used, hs_stat, third_port_lines_in);
      end
      default: begin
        // The setup word cannot be read back.
        rd_byte = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_q) begin
      avs_readdata <= mapped ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

endmodule
